// [src/pamc_top.sv]
/*
  eight-macrocell programmable and-or array with axi4-lite fuse access.
  assumes: pins synchronous to mclk; fuse map and config written by software.
*/
// The implementer's own choices: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module pamc_top (
  input  wire logic                        mclk,
  input  wire logic                        arst_n,
  input  wire logic [pamc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [31:0]                 s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  output logic [1:0]                       s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  input  wire logic [pamc_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  output logic [31:0]                      s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  input  wire logic [pamc_pkg::NIN-1:0]    inPin,
  input  wire logic                        clkPin,
  input  wire logic [pamc_pkg::NMC-1:0]    ioIn,
  output logic [pamc_pkg::NMC-1:0]         ioOut,
  output logic [pamc_pkg::NMC-1:0]         ioOe
);
  import pamc_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic [NTERM-1:0][2*NLINE-1:0] fuse;
    logic [NMC-1:0]                pol;
    logic [NMC-1:0]                byp;
    logic                          clkIn;
    logic [NMC-1:0]                q;
    logic                          clkPrev;
    logic [NMC-1:0]                out;
    logic [NMC-1:0]                oe;
    logic                          awHave;
    logic [ADDR_W-1:0]             awAddr;
    logic                          wHave;
    logic [31:0]                   wData;
    logic [3:0]                    wStrb;
    logic                          bValid;
    logic [1:0]                    bResp;
    logic                          rValid;
    logic [31:0]                   rData;
    logic [1:0]                    rResp;
  } pamc_state_t;

  localparam pamc_state_t ST_RST = '{fuse: {NTERM{FUSE_RST}}, q: Q_RST, default: '0};

  pamc_state_t    st_r;
  pamc_state_t    st_nxt;
  logic [NMC-1:0] fb;
  logic [NMC-1:0] sop;
  logic [NMC-1:0] oeT;
  logic           preT;
  logic           rstT;
  logic           clkRise;
  logic           plWr;
  logic [NMC-1:0] plData;
  logic           awRdy;
  logic           wRdy;
  logic           arRdy;

  pamc_array_if arr ();

  pamc_and_array u_array (
    .arr (arr.array)
  );

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] mergeW(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0]  strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) r[8*b +: 8] = nw[8*b +: 8];
    end
    return r;
  endfunction

  function automatic logic fuseHit(input logic [ADDR_W-1:0] a);
    return (a >= FUSE_OFF) && (a <= FUSE_END) && (a[1:0] == 2'h0);
  endfunction

  // two words per term: low word holds links 31..0, high word links 39..32
  function automatic logic [ADDR_W-5:0] fuseTerm(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] d;
    d = a - FUSE_OFF;
    return d[ADDR_W-2:3];
  endfunction

  function automatic logic fuseHigh(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] d;
    d = a - FUSE_OFF;
    return d[2];
  endfunction

  function automatic logic sumOf(input logic [NTERM-1:0] t, input int i);
    logic s;
    s = 1'b0;
    for (int k = 0; k < NBIG; k++) begin
      if (k < termCount(i)) s = s | t[sumBase(i) + k];
    end
    return s;
  endfunction

  // ----------------------------------------
  // array wiring
  // ----------------------------------------
  // a pin in clock use reads low in the array so no term sees the clock
  assign fb        = (st_r.byp & ioIn) | (~st_r.byp & st_r.q);
  assign arr.lines = {fb, st_r.clkIn & clkPin, inPin};
  assign arr.fuse  = st_r.fuse;
  assign oeT       = arr.term[TERM_OE +: NMC];
  assign preT      = arr.term[TERM_PRE];
  assign rstT      = arr.term[TERM_RST];
  assign clkRise   = !st_r.clkIn && clkPin && !st_r.clkPrev;

  for (genvar g = 0; g < NMC; g++) begin : g_sum
    assign sop[g] = sumOf(arr.term, g);
  end

  assign awRdy = !st_r.awHave && !st_r.bValid;
  assign wRdy  = !st_r.wHave && !st_r.bValid;
  assign arRdy = !st_r.rValid;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    logic [31:0]       tmp;
    logic [ADDR_W-5:0] ti;
    st_nxt = st_r;
    plWr   = 1'b0;
    plData = st_r.wData[NMC-1:0];
    tmp    = '0;
    ti     = fuseTerm(st_r.awAddr);
    // write: address and data may come in either order
    if (st_r.awHave && st_r.wHave && !st_r.bValid) begin
      st_nxt.awHave = 1'b0;
      st_nxt.wHave  = 1'b0;
      st_nxt.bValid = 1'b1;
      st_nxt.bResp  = RESP_OK;
      if (st_r.awAddr == CFG_OFF) begin
        tmp = mergeW({15'h0, st_r.clkIn, st_r.byp, st_r.pol}, st_r.wData, st_r.wStrb);
        st_nxt.pol   = tmp[CFG_POL_LSB +: NMC];
        st_nxt.byp   = tmp[CFG_BYP_LSB +: NMC];
        st_nxt.clkIn = tmp[CFG_CLK_BIT];
      end else if (st_r.awAddr == PRELOAD_OFF) begin
        plWr = st_r.wStrb[0];
      end else if (fuseHit(st_r.awAddr)) begin
        if (fuseHigh(st_r.awAddr)) begin
          tmp = mergeW({24'h0, st_r.fuse[ti][39:32]}, st_r.wData, st_r.wStrb);
          st_nxt.fuse[ti][39:32] = tmp[7:0];
        end else begin
          st_nxt.fuse[ti][31:0] = mergeW(st_r.fuse[ti][31:0], st_r.wData, st_r.wStrb);
        end
      end else if (st_r.awAddr != STATE_OFF && st_r.awAddr != PIN_OFF) begin
        st_nxt.bResp = RESP_SLVERR;
      end
    end
    if (s_axi_awvalid && awRdy) begin
      st_nxt.awHave = 1'b1;
      st_nxt.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && wRdy) begin
      st_nxt.wHave = 1'b1;
      st_nxt.wData = s_axi_wdata;
      st_nxt.wStrb = s_axi_wstrb;
    end
    if (st_r.bValid && s_axi_bready) st_nxt.bValid = 1'b0;
    // read
    if (st_r.rValid && s_axi_rready) st_nxt.rValid = 1'b0;
    if (s_axi_arvalid && arRdy) begin
      st_nxt.rValid = 1'b1;
      st_nxt.rResp  = RESP_OK;
      st_nxt.rData  = '0;
      if (s_axi_araddr == CFG_OFF) begin
        st_nxt.rData[CFG_POL_LSB +: NMC] = st_r.pol;
        st_nxt.rData[CFG_BYP_LSB +: NMC] = st_r.byp;
        st_nxt.rData[CFG_CLK_BIT]        = st_r.clkIn;
      end else if (s_axi_araddr == STATE_OFF) begin
        st_nxt.rData[NMC-1:0]           = st_r.q;
        st_nxt.rData[ST_OE_LSB +: NMC]  = st_r.oe;
        st_nxt.rData[ST_OUT_LSB +: NMC] = st_r.out;
      end else if (s_axi_araddr == PIN_OFF) begin
        st_nxt.rData[NIN:0] = {clkPin, inPin};
      end else if (fuseHit(s_axi_araddr)) begin
        if (fuseHigh(s_axi_araddr)) begin
          st_nxt.rData[7:0] = st_r.fuse[fuseTerm(s_axi_araddr)][39:32];
        end else begin
          st_nxt.rData = st_r.fuse[fuseTerm(s_axi_araddr)][31:0];
        end
      end else if (s_axi_araddr != PRELOAD_OFF) begin
        st_nxt.rResp = RESP_SLVERR;
      end
    end
    // macrocell flip-flops: overrides act every mclk, not only on clock edges
    if (rstT) begin
      st_nxt.q = Q_RST;
    end else if (preT) begin
      st_nxt.q = Q_PRE;
    end else if (plWr) begin
      st_nxt.q = plData;
    end else if (clkRise) begin
      st_nxt.q = sop;
    end
    st_nxt.clkPrev = clkPin;
    // pins are re-timed by one mclk, trading a cycle for a loop-free ioIn path
    st_nxt.out = ((st_r.byp & sop) | (~st_r.byp & st_r.q)) ^ st_r.pol;
    st_nxt.oe  = oeT;
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= ST_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign s_axi_awready = awRdy;
  assign s_axi_wready  = wRdy;
  assign s_axi_bvalid  = st_r.bValid;
  assign s_axi_bresp   = st_r.bResp;
  assign s_axi_arready = arRdy;
  assign s_axi_rvalid  = st_r.rValid;
  assign s_axi_rdata   = st_r.rData;
  assign s_axi_rresp   = st_r.rResp;
  assign ioOut         = st_r.out;
  assign ioOe          = st_r.oe;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  reset_wins_a:
    assert property (rstT |=> st_r.q == Q_RST)
    else $error("reset term did not clear the flip-flops");
  preset_sets_a:
    assert property (preT && !rstT |=> st_r.q == Q_PRE)
    else $error("preset term did not set the flip-flops");
  clk_capture_a:
    assert property (clkRise && !preT && !rstT && !plWr |=> st_r.q == $past(sop))
    else $error("flip-flops missed the sum on a clock pin edge");
  q_holds_a:
    assert property (!clkRise && !preT && !rstT && !plWr |=> $stable(st_r.q))
    else $error("flip-flops changed without cause");
  preload_a:
    assert property (plWr && !preT && !rstT |=> st_r.q == $past(plData))
    else $error("preload value not loaded");
  oe_term_a:
    assert property (##1 ioOe == $past(oeT))
    else $error("pin enable does not follow its term");
  input_only_a:
    assert property (oeT == 8'h00 [*2] |=> ioOe == 8'h00)
    else $error("pin driven while its enable term is low");
  reg_polarity_a:
    assert property (st_r.byp == 8'h00 |=> ioOut == ($past(st_r.q) ^ $past(st_r.pol)))
    else $error("registered output wrong for its polarity");
  comb_path_a:
    assert property (st_r.byp == 8'hff |=> ioOut == ($past(sop) ^ $past(st_r.pol)))
    else $error("combinatorial output does not follow the sum");
  blank_term_a:
    assert property (&st_r.fuse[TERM_PRE][1:0] |-> !preT)
    else $error("term with both links intact went active");
  bresp_hold_a:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before taken");

  // fixed answer times let a master pace itself without counting on slack
  rd_answer_a:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  wr_answer_a:
    assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
                     |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write response not two cycles after the take");
  aw_blocked_a:
    assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("new write taken while a response is pending");
  rd_slverr_a:
    assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > PIN_OFF
                     && !fuseHit(s_axi_araddr) |=> s_axi_rresp == RESP_SLVERR)
    else $error("unmapped read answered okay");
  clk_ignored_a:
    assert property (st_r.clkIn && !preT && !rstT && !plWr |=> $stable(st_r.q))
    else $error("flip-flops clocked while the clock pin is a line");
  clk_line_a:
    assert property (!st_r.clkIn |-> !arr.lines[NIN])
    else $error("clock pin leaked into the array");
  fb_reg_a:
    assert property (st_r.byp == 8'h00 |-> arr.lines[NIN+1 +: NMC] == st_r.q)
    else $error("registered cells do not feed back the stored bits");
  fb_pin_a:
    assert property (st_r.byp == 8'hff |-> arr.lines[NIN+1 +: NMC] == ioIn)
    else $error("combinatorial cells do not feed back their pins");
  preset_pins_a:
    assert property (st_r.q == Q_PRE && st_r.byp == 8'h00 |=> ioOut == ~$past(st_r.pol))
    else $error("preset state shows wrong pin levels");

  preload_run_c:  cover property (plWr ##[1:20] clkRise);
  preset_c:       cover property (preT && !rstT);
  both_ovr_c:     cover property (preT && rstT);
  pin_input_c:    cover property (st_r.byp[0] && !ioOe[0]);
  slverr_c:       cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
endmodule
`default_nettype wire

// [src/pamc_pkg.sv]
/*
  constants, register map and term layout of the macrocell logic array.
  assumes: nothing; imported by every design file of the block.
*/
package pamc_pkg;
  // ----------------------------------------
  // array shape
  // ----------------------------------------
  localparam int NIN      = 11;
  localparam int NMC      = 8;
  localparam int NLINE    = 20;
  localparam int NTERM    = 90;
  localparam int NSMALL   = 8;
  localparam int NBIG     = 12;
  localparam int TERM_OE  = 80;
  localparam int TERM_PRE = 88;
  localparam int TERM_RST = 89;
  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam int             ADDR_W      = 12;
  localparam logic [11:0]    CFG_OFF     = 12'h000;
  localparam logic [11:0]    PRELOAD_OFF = 12'h004;
  localparam logic [11:0]    STATE_OFF   = 12'h008;
  localparam logic [11:0]    PIN_OFF     = 12'h00c;
  localparam logic [11:0]    FUSE_OFF    = 12'h400;
  localparam logic [11:0]    FUSE_END    = 12'h6cc;
  localparam int             CFG_POL_LSB = 0;
  localparam int             CFG_BYP_LSB = 8;
  localparam int             CFG_CLK_BIT = 16;
  localparam int             ST_OUT_LSB  = 16;
  localparam int             ST_OE_LSB   = 8;
  localparam logic [39:0]    FUSE_RST    = 40'hff_ffff_ffff;
  localparam logic [7:0]     Q_RST       = 8'h00;
  localparam logic [7:0]     Q_PRE       = 8'hff;
  localparam logic [1:0]     RESP_OK     = 2'h0;
  localparam logic [1:0]     RESP_SLVERR = 2'h2;

  // first sum term of macrocell i: four cells of eight, then four of twelve
  function automatic int sumBase(input int i);
    return (i < 4) ? i * NSMALL : 4 * NSMALL + (i - 4) * NBIG;
  endfunction

  function automatic int termCount(input int i);
    return (i < 4) ? NSMALL : NBIG;
  endfunction
endpackage

// [src/pamc_array_if.sv]
/*
  carrier between the macrocell top and the and-array.
  assumes: lines and fuse driven by pamc_top, term driven by pamc_and_array and read by pamc_top.
*/
`timescale 1ns/1ps
`default_nettype none
interface pamc_array_if;
  import pamc_pkg::*;
  logic [NLINE-1:0]                  lines;
  logic [NTERM-1:0][2*NLINE-1:0]     fuse;
  logic [NTERM-1:0]                  term;
  modport array (input lines, input fuse, output term);
  modport ctrl  (output lines, output fuse, input term);
endinterface
`default_nettype wire

// [src/pamc_and_array.sv]
/*
  programmable and-array: every product term from the fuse map.
  assumes: fuse bit 2k is the true link of line k, 2k+1 the complement link;
  a set bit means the link is intact.
*/
`timescale 1ns/1ps
`default_nettype none
module pamc_and_array (
  pamc_array_if.array arr
);
  import pamc_pkg::*;

  // ----------------------------------------
  // product term
  // ----------------------------------------
  // both links intact on a line forces the term low, so a blank term is dead
  function automatic logic prodTerm(input logic [2*NLINE-1:0] f,
                                    input logic [NLINE-1:0]   x);
    logic r;
    r = 1'b1;
    for (int k = 0; k < NLINE; k++) begin
      r = r & (~f[2*k] | x[k]) & (~f[2*k+1] | ~x[k]);
    end
    return r;
  endfunction

  always_comb begin
    for (int t = 0; t < NTERM; t++) begin
      arr.term[t] = prodTerm(arr.fuse[t], arr.lines);
    end
  end
endmodule
`default_nettype wire

// [dv/pamc_pins_model.sv]
/*
  surrounding board logic on the eight macrocell pins: resolves each pin level.
  assumes: the bench chooses which pins it drives through extEn and extVal.
*/
`timescale 1ns/1ps
`default_nettype none
module pamc_pins_model (
  input  wire logic       mclk,
  input  wire logic       arstN,
  input  wire logic [7:0] ioOut,
  input  wire logic [7:0] ioOe,
  input  wire logic [7:0] extVal,
  input  wire logic [7:0] extEn,
  output logic      [7:0] ioIn
);
  // ----------------------------------------
  // pin resolution
  // ----------------------------------------
  logic [7:0] junk_r;

  // an undriven pin must not look like a clean level, so it toggles each cycle
  always_ff @(posedge mclk or negedge arstN) begin
    if (!arstN) begin
      junk_r <= 8'h55;
    end else begin
      junk_r <= ~junk_r;
    end
  end

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      ioIn[i] = ioOe[i] ? ioOut[i] : (extEn[i] ? extVal[i] : junk_r[i]);
    end
  end
endmodule
`default_nettype wire

// [dv/testbench.sv]
/*
  self-checking bench: fuse map set over axi4-lite, pins driven and watched.
  assumes: pamc_pkg, pamc_top and pamc_pins_model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import pamc_pkg::*;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic        mclk = 1'b0;
  logic        arstN = 1'b0;
  logic [11:0] awAddr = 12'h000;
  logic [11:0] arAddr = 12'h000;
  logic [31:0] wData = 32'h0;
  logic [3:0]  wStrb = 4'hf;
  logic        awValid = 1'b0;
  logic        wValid = 1'b0;
  logic        arValid = 1'b0;
  logic        awReady, wReady, bValid, arReady, rValid;
  logic [1:0]  bResp, rResp, resp;
  logic [31:0] rData, rdVal;
  logic [10:0] inPins = 11'h000;
  logic        clkPin = 1'b0;
  logic [7:0]  ioIn, ioOut, ioOe, snapOut, snapOe;
  logic [7:0]  extVal = 8'h00;
  logic [7:0]  extEn = 8'hff;
  int          num_errors = 0;
  int          n_tests = 0;

  always #2 mclk = ~mclk;

  // bready and rready held high: the bench never stalls a response
  pamc_top DUT (.mclk(mclk), .arst_n(arstN), .s_axi_awaddr(awAddr),
    .s_axi_awvalid(awValid), .s_axi_awready(awReady), .s_axi_wdata(wData),
    .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
    .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(1'b1),
    .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
    .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid),
    .s_axi_rready(1'b1), .inPin(inPins), .clkPin(clkPin), .ioIn(ioIn),
    .ioOut(ioOut), .ioOe(ioOe));

  pamc_pins_model pins (.mclk(mclk), .arstN(arstN), .ioOut(ioOut), .ioOe(ioOe),
    .extVal(extVal), .extEn(extEn), .ioIn(ioIn));

  // ----------------------------------------
  // report and compare
  // ----------------------------------------
  task automatic finish_test;
    $display("checks %0d, mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic cmpWord(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic cmpResp(input string what, input logic [1:0] exp, input logic [1:0] got);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic hang;
    num_errors++;
    $display("unexpected handshake: expected an answer, seen none");
    finish_test();
  endtask

  // ----------------------------------------
  // bus and pin helpers
  // ----------------------------------------
  // ready is sampled at the falling edge so the take edge is known without a race
  task automatic axiWr(input logic [11:0] a, input logic [31:0] d);
    logic awOk, wOk, bOk;
    int   k;
    awOk = 1'b0;
    wOk = 1'b0;
    bOk = 1'b0;
    @(posedge mclk);
    awAddr <= a;
    wData <= d;
    awValid <= 1'b1;
    wValid <= 1'b1;
    for (k = 0; k < 64 && !bOk; k++) begin
      @(negedge mclk);
      if (bValid === 1'b1) begin
        bOk = 1'b1;
        resp = bResp;
      end
      if (!awOk && awReady === 1'b1) begin
        awOk = 1'b1;
      end
      if (!wOk && wReady === 1'b1) begin
        wOk = 1'b1;
      end
      @(posedge mclk);
      if (awOk) begin
        awValid <= 1'b0;
      end
      if (wOk) begin
        wValid <= 1'b0;
      end
    end
    if (!bOk) begin
      hang();
    end
  endtask

  task automatic axiRd(input logic [11:0] a);
    logic arOk, rOk;
    int   k;
    arOk = 1'b0;
    rOk = 1'b0;
    @(posedge mclk);
    arAddr <= a;
    arValid <= 1'b1;
    for (k = 0; k < 64 && !rOk; k++) begin
      @(negedge mclk);
      if (arOk && rValid === 1'b1) begin
        rOk = 1'b1;
        rdVal = rData;
        resp = rResp;
      end
      if (!arOk && arReady === 1'b1) begin
        arOk = 1'b1;
      end
      @(posedge mclk);
      if (arOk) begin
        arValid <= 1'b0;
      end
    end
    if (!rOk) begin
      hang();
    end
  endtask

  task automatic setTerm(input int t, input logic [31:0] lo, input logic [7:0] hi);
    axiWr(FUSE_OFF + 12'(8 * t), lo);
    axiWr(FUSE_OFF + 12'(8 * t + 4), {24'h0, hi});
  endtask

  task automatic blank(input int t);
    setTerm(t, 32'hffff_ffff, 8'hff);
  endtask

  // pins answer one mclk after their cause; snapshot taken mid-cycle
  task automatic settle;
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    snapOut = ioOut;
    snapOe = ioOe;
    @(posedge mclk);
  endtask

  task automatic clkPulse;
    clkPin <= 1'b1;
    repeat (2) @(posedge mclk);
    clkPin <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic tReset;
    axiRd(STATE_OFF);
    cmpWord("state after reset", 32'h0, rdVal);
    axiRd(FUSE_OFF + 12'h004);
    cmpWord("blank fuse word", 32'h0000_00ff, rdVal);
    axiRd(12'h3f0);
    cmpResp("unmapped read", RESP_SLVERR, resp);
    cmpWord("unmapped read data", 32'h0, rdVal);
    axiWr(12'h3f0, 32'h1);
    cmpResp("unmapped write", RESP_SLVERR, resp);
    wStrb <= 4'h2;
    axiWr(CFG_OFF, 32'h0001_ff55);
    cmpResp("cfg write", RESP_OK, resp);
    wStrb <= 4'hf;
    axiRd(CFG_OFF);
    cmpWord("cfg byte lane", 32'h0000_ff00, rdVal);
  endtask

  task automatic tComb;
    axiWr(CFG_OFF, 32'h0000_ff00);
    setTerm(0, 32'h1, 8'h0);
    setTerm(43, 32'h40, 8'h0);
    setTerm(44, 32'h3, 8'h0);
    for (int v = 0; v < 2; v++) begin
      inPins <= v ? 11'h009 : 11'h000;
      settle();
      cmpWord("sum outputs", v ? 32'h11 : 32'h0, {24'h0, snapOut});
    end
    axiWr(CFG_OFF, 32'h0000_ff01);
    settle();
    cmpWord("inverted output", 32'h10, {24'h0, snapOut});
    inPins <= 11'h000;
    blank(0);
    setTerm(1, 32'h0040_0000, 8'h0);
    axiWr(CFG_OFF, 32'h0001_ff00);
    clkPin <= 1'b1;
    settle();
    cmpWord("clock pin as line", 32'h01, {24'h0, snapOut});
    clkPin <= 1'b0;
    blank(1);
    blank(43);
    blank(44);
  endtask

  task automatic tEnable;
    setTerm(8, 32'h0400_0000, 8'h0);
    extVal <= 8'h02;
    settle();
    cmpWord("pin fed back", 32'h0002, {16'h0, snapOe, snapOut});
    extVal <= 8'h00;
    setTerm(82, 32'h100, 8'h0);
    inPins <= 11'h010;
    settle();
    cmpWord("enable term high", 32'h0400, {16'h0, snapOe, snapOut});
    inPins <= 11'h000;
    settle();
    cmpWord("enable term low", 32'h0, {16'h0, snapOe, snapOut});
    blank(8);
    blank(82);
  endtask

  task automatic tReg;
    axiWr(CFG_OFF, 32'h0);
    setTerm(0, 32'h0200_0000, 8'h0);
    axiWr(PRELOAD_OFF, 32'h0000_00a4);
    axiRd(STATE_OFF);
    cmpWord("preloaded state", 32'h00a4_00a4, rdVal);
    clkPulse();
    axiRd(STATE_OFF);
    cmpWord("state after clock", 32'h0001_0001, rdVal);
    clkPulse();
    axiRd(STATE_OFF);
    cmpWord("state after clock", 32'h0, rdVal);
  endtask

  task automatic tPreRst;
    setTerm(88, 32'h4, 8'h0);
    setTerm(89, 32'h10, 8'h0);
    axiWr(CFG_OFF, 32'h0000_000f);
    inPins <= 11'h002;
    settle();
    cmpWord("preset pins", 32'hf0, {24'h0, snapOut});
    inPins <= 11'h006;
    settle();
    cmpWord("preset and reset", 32'h0f, {24'h0, snapOut});
    inPins <= 11'h004;
    settle();
    cmpWord("reset pins", 32'h0f, {24'h0, snapOut});
    inPins <= 11'h000;
    blank(88);
    blank(89);
  endtask

  initial begin
    repeat (5) @(posedge mclk);
    arstN <= 1'b1;
    tReset();
    tComb();
    tEnable();
    tReg();
    tPreRst();
    finish_test();
  end
endmodule
`default_nettype wire
